// *** verilog/stm_target.sv ***
// target end: parses messages out, enforces ordering and nexus, performs clears
// assumes the initiator presents one byte at a time and holds it until out_ready
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - extended message: 01h, length, code, args
// - length zero means 256 bytes follow
// - decode codes 00h, 01h, 03h
// - 02h, 04h-7Fh reserved; 80h+ vendor
// - initiator first message: identify/abort/reset
// - other first message gives bus free
// - queue tag directly follows identify
// - after reselection target sends identify first
// - different second identify gives bus free
// - initiator aligns pointers when nexus set; the code does so at selection only with disc_allowed
// - initiator restores pointers on reconnection
// - abort clears initiator unit processes
// - abort without identify: bus free only
// - abort accepted with nothing queued
// - clears keep mode, reservation, allegiance
// - abort tag implemented for tagged queuing
// - abort tag clears current process only
// - abort tag before full identify: no abort
// - bus device reset clears all, unit attention
// - clear queue clears unit for all
// - unit attention for other affected initiators
// - first byte one starts extended message
module stm_target (
  stm_link_if.target link,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [stm_pkg::NEXUS_W-1:0] resel_lun,
  input wire logic resel_start,
  input wire logic resel_tagged,
  input wire logic other_init_active,
  output logic [stm_pkg::NEXUS_W-1:0] nexus_lun,
  output logic nexus_valid,
  output logic tag_valid,
  output logic [7:0] tag_value,
  output stm_pkg::stm_action_t action,
  output logic action_stb,
  output logic unit_atten_all,
  output logic unit_atten_others,
  output logic unexpected_disc,
  output logic ext_done_stb,
  output stm_pkg::stm_ext_t ext_kind,
  output logic [7:0] ext_code
);
  import stm_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FIRST, ST_AFTER_ID, ST_MSG, ST_TAG_ARG, ST_EXT_LEN, ST_EXT_CODE, ST_EXT_ARGS
  } stm_state_t;
  stm_state_t state_reg;
  logic [8:0] ext_left_reg;
  logic reject_pend_reg;
  logic resel_send_reg;
  logic bus_free_reg;
  logic full_id_reg;
  logic [7:0] in_byte_reg;
  logic in_valid_reg;
  logic [7:0] b;
  logic take;
  function automatic logic is_identify(input logic [7:0] v);
    return (v & IDENTIFY_FLAG) != 8'h00;
  endfunction
  function automatic logic is_tag(input logic [7:0] v);
    return v == MSG_SIMPLE_TAG || v == MSG_HEAD_TAG || v == MSG_ORDERED_TAG;
  endfunction
  assign b = link.out_byte;
  assign take = link.out_valid && link.out_ready;
  // stall out while a reply byte waits, so replies are never overrun
  assign link.out_ready = !in_valid_reg && !bus_free_reg;
  assign link.in_valid = in_valid_reg;
  assign link.in_byte = in_byte_reg;
  assign link.bus_free = bus_free_reg;
  assign link.reselect = resel_send_reg;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ext_left_reg <= 9'h000;
      nexus_lun <= '0;
      nexus_valid <= 1'b0;
      full_id_reg <= 1'b0;
      tag_valid <= 1'b0;
      tag_value <= 8'h00;
      action <= STM_ACT_NONE;
      action_stb <= 1'b0;
      unit_atten_all <= 1'b0;
      unit_atten_others <= 1'b0;
      unexpected_disc <= 1'b0;
      bus_free_reg <= 1'b0;
      reject_pend_reg <= 1'b0;
      ext_done_stb <= 1'b0;
      ext_kind <= STM_EXT_OTHER;
      ext_code <= 8'h00;
    end else begin
      action_stb <= 1'b0;
      unit_atten_all <= 1'b0;
      unit_atten_others <= 1'b0;
      unexpected_disc <= 1'b0;
      ext_done_stb <= 1'b0;
      reject_pend_reg <= 1'b0;
      bus_free_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (link.select) begin
            state_reg <= ST_FIRST;
            nexus_valid <= 1'b0;
            full_id_reg <= 1'b0;
            tag_valid <= 1'b0;
          end else if (resel_start) begin
            state_reg <= ST_AFTER_ID;
            nexus_lun <= resel_lun;
            nexus_valid <= 1'b1;
            full_id_reg <= !resel_tagged;
            tag_valid <= 1'b0;
          end
        end
        ST_FIRST: if (take) begin
          if (is_identify(b)) begin
            nexus_lun <= b[NEXUS_W-1:0];
            nexus_valid <= 1'b1;
            full_id_reg <= 1'b1;
            state_reg <= ST_AFTER_ID;
          end else if (b == MSG_ABORT) begin
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (b == MSG_BUS_DEV_RESET) begin
            action <= STM_ACT_RESET;
            action_stb <= 1'b1;
            unit_atten_all <= 1'b1;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            unexpected_disc <= 1'b1;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        ST_AFTER_ID, ST_MSG: if (take) begin
          if (state_reg == ST_AFTER_ID && is_tag(b)) begin
            state_reg <= ST_TAG_ARG;
          end else if (is_identify(b)) begin
            if (b[NEXUS_W-1:0] != nexus_lun) begin
              unexpected_disc <= 1'b1;
              bus_free_reg <= 1'b1;
              state_reg <= ST_IDLE;
            end else begin
              state_reg <= ST_MSG;
            end
          end else if (b == MSG_EXTENDED) begin
            state_reg <= ST_EXT_LEN;
          end else if (b == MSG_ABORT) begin
            action <= STM_ACT_ABORT;
            action_stb <= 1'b1;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (b == MSG_ABORT_TAG) begin
            action <= full_id_reg ? STM_ACT_ABORT_TAG : STM_ACT_NONE;
            action_stb <= full_id_reg;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (b == MSG_CLEAR_QUEUE) begin
            action <= STM_ACT_CLEAR_Q;
            action_stb <= 1'b1;
            unit_atten_others <= other_init_active;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (b == MSG_BUS_DEV_RESET) begin
            action <= STM_ACT_RESET;
            action_stb <= 1'b1;
            unit_atten_all <= 1'b1;
            bus_free_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end else begin
            reject_pend_reg <= 1'b1;
            state_reg <= ST_MSG;
          end
        end
        ST_TAG_ARG: if (take) begin
          tag_value <= b;
          tag_valid <= 1'b1;
          full_id_reg <= 1'b1;
          state_reg <= ST_MSG;
        end
        ST_EXT_LEN: if (take) begin
          ext_left_reg <= (b == 8'h00) ? EXT_ZERO_LEN_COUNT : {1'b0, b};
          state_reg <= ST_EXT_CODE;
        end
        ST_EXT_CODE: if (take) begin
          ext_code <= b;
          ext_left_reg <= ext_left_reg - 9'h001;
          case (b)
            EXT_MODIFY_PTR: ext_kind <= STM_EXT_MODIFY;
            EXT_SYNC_REQ: ext_kind <= STM_EXT_SYNC;
            EXT_WIDE_REQ: ext_kind <= STM_EXT_WIDE;
            default: ext_kind <= STM_EXT_OTHER;
          endcase
          if (ext_left_reg == 9'h001) begin
            ext_done_stb <= 1'b1;
            state_reg <= ST_MSG;
          end else begin
            state_reg <= ST_EXT_ARGS;
          end
        end
        ST_EXT_ARGS: if (take) begin
          ext_left_reg <= ext_left_reg - 9'h001;
          if (ext_left_reg == 9'h001) begin
            ext_done_stb <= 1'b1;
            state_reg <= ST_MSG;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // reply path: reject for unknown codes, identify on reselection
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid_reg <= 1'b0;
      in_byte_reg <= 8'h00;
      resel_send_reg <= 1'b0;
    end else begin
      resel_send_reg <= 1'b0;
      if (in_valid_reg && link.in_ready) begin
        in_valid_reg <= 1'b0;
      end
      if (state_reg == ST_IDLE && resel_start && !link.select) begin
        resel_send_reg <= 1'b1;
        in_valid_reg <= 1'b1;
        in_byte_reg <= IDENTIFY_FLAG | {{(8-NEXUS_W){1'b0}}, resel_lun};
      end else if (reject_pend_reg) begin
        in_valid_reg <= 1'b1;
        in_byte_reg <= MSG_REJECT;
      end else if (ext_done_stb && ext_kind == STM_EXT_OTHER) begin
        in_valid_reg <= 1'b1;
        in_byte_reg <= MSG_REJECT;
      end
    end
  end
endmodule
`default_nettype wire

// *** verilog/stm_pkg.sv ***
// package: message codes, extended codes and sizes for the target message handler
// assumes a single 40 mhz core clock shared by both ends
package stm_pkg;
  localparam logic [7:0] MSG_EXTENDED = 8'h01;
  localparam logic [7:0] MSG_ABORT = 8'h06;
  localparam logic [7:0] MSG_REJECT = 8'h07;
  localparam logic [7:0] MSG_BUS_DEV_RESET = 8'h0c;
  localparam logic [7:0] MSG_ABORT_TAG = 8'h0d;
  localparam logic [7:0] MSG_CLEAR_QUEUE = 8'h0e;
  localparam logic [7:0] MSG_SIMPLE_TAG = 8'h20;
  localparam logic [7:0] MSG_HEAD_TAG = 8'h21;
  localparam logic [7:0] MSG_ORDERED_TAG = 8'h22;
  localparam logic [7:0] IDENTIFY_FLAG = 8'h80;
  localparam logic [7:0] EXT_MODIFY_PTR = 8'h00;
  localparam logic [7:0] EXT_SYNC_REQ = 8'h01;
  localparam logic [7:0] EXT_OLD_IDENT = 8'h02;
  localparam logic [7:0] EXT_WIDE_REQ = 8'h03;
  localparam logic [7:0] EXT_VENDOR_BASE = 8'h80;
  localparam logic [8:0] EXT_ZERO_LEN_COUNT = 9'h100;
  localparam int EXT_MIN_BYTES = 3;
  localparam int NEXUS_W = 4;
  typedef enum logic [2:0] {
    STM_ACT_NONE, STM_ACT_ABORT, STM_ACT_ABORT_TAG, STM_ACT_RESET, STM_ACT_CLEAR_Q
  } stm_action_t;
  typedef enum logic [1:0] {
    STM_EXT_MODIFY, STM_EXT_SYNC, STM_EXT_WIDE, STM_EXT_OTHER
  } stm_ext_t;
endpackage

// *** verilog/stm_link_if.sv ***
// interface: message byte link between target and initiator ends
// assumes both ends on one clock; valid/ready stand in for req/ack
`timescale 1ns/1ps
`default_nettype none
interface stm_link_if;
  logic out_valid;
  logic out_ready;
  logic [7:0] out_byte;
  logic out_atn;
  logic in_valid;
  logic in_ready;
  logic [7:0] in_byte;
  logic bus_free;
  logic reselect;
  logic select;
  modport target (input out_valid, input out_byte, input out_atn, output out_ready,
    output in_valid, output in_byte, input in_ready, output bus_free,
    input select, output reselect);
  modport initiator (output out_valid, output out_byte, output out_atn, input out_ready,
    input in_valid, input in_byte, output in_ready, input bus_free,
    output select, input reselect);
endinterface
`default_nettype wire

// *** verilog/stm_initiator.sv ***
// initiator end: sends a queued message stream and tracks data pointers
// assumes the user loads whole messages byte by byte through msg_valid/msg_ready
`timescale 1ns/1ps
`default_nettype none
module stm_initiator #(
  parameter int PTR_W = 32
) (
  stm_link_if.initiator link,
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sel_start,
  input wire logic msg_valid,
  input wire logic [7:0] msg_byte,
  output logic msg_ready,
  input wire logic [PTR_W-1:0] saved_ptr,
  input wire logic disc_allowed,
  output logic [PTR_W-1:0] cur_ptr,
  output logic [7:0] rx_byte,
  output logic rx_stb,
  output logic bus_free_seen
);
  import stm_pkg::*;
  assign link.select = sel_start;
  assign link.out_valid = msg_valid;
  assign link.out_byte = msg_byte;
  assign link.out_atn = msg_valid;
  assign msg_ready = link.out_ready;
  assign link.in_ready = 1'b1;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cur_ptr <= '0;
    end else if ((sel_start && disc_allowed) || link.reselect) begin
      cur_ptr <= saved_ptr;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= 8'h00;
      rx_stb <= 1'b0;
      bus_free_seen <= 1'b0;
    end else begin
      rx_stb <= link.in_valid;
      bus_free_seen <= link.bus_free;
      if (link.in_valid) begin
        rx_byte <= link.in_byte;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/stm_link_asserts.sv ***
// checker: timing relations on the message link between the two ends
// assumes one clock and the link signals wired in by the bench
`timescale 1ns/1ps
`default_nettype none
module stm_link_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [7:0] out_byte,
  input wire logic out_atn,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic [7:0] in_byte,
  input wire logic bus_free,
  input wire logic reselect,
  input wire logic select
);
  import stm_pkg::*;
  logic take;
  logic first_reg;
  logic [7:0] prev_reg;
  assign take = out_valid && out_ready;
  // last taken byte, so identify followed by a message can be spotted
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_reg <= 8'h00;
    end else if (take) begin
      prev_reg <= out_byte;
    end
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      first_reg <= 1'b0;
    end else if (select) begin
      first_reg <= 1'b1;
    end else if (take) begin
      first_reg <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_first_bad;
    take && first_reg && !out_byte[7];
  endsequence
  sequence s_ident_abort;
    take && !first_reg && prev_reg[7] && out_byte == MSG_ABORT;
  endsequence
  sequence s_ident_change;
    take && !first_reg && prev_reg[7] && out_byte[7] &&
      out_byte[NEXUS_W-1:0] != prev_reg[NEXUS_W-1:0];
  endsequence
  property p_free_pulse;
    bus_free |=> !bus_free;
  endproperty
  a_free_pulse: assert property (p_free_pulse) else $error("bus free too long");
  property p_refuse;
    bus_free || in_valid |-> !out_ready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("byte taken while busy");
  property p_in_hold;
    in_valid && !in_ready |=> in_valid && $stable(in_byte);
  endproperty
  a_in_hold: assert property (p_in_hold) else $error("inbound byte dropped");
  property p_resel_ident;
    reselect |-> ##[0:8] in_valid && in_byte[7];
  endproperty
  a_resel_ident: assert property (p_resel_ident) else $error("no identify");
  property p_reject;
    in_valid && !in_byte[7] |-> in_byte == MSG_REJECT;
  endproperty
  a_reject: assert property (p_reject) else $error("bad inbound byte");
  property p_first_bad;
    s_first_bad |=> bus_free;
  endproperty
  a_first_bad: assert property (p_first_bad) else $error("no bus free");
  property p_abort_free;
    s_ident_abort |=> bus_free;
  endproperty
  a_abort_free: assert property (p_abort_free) else $error("abort kept bus");
  property p_ident_change;
    s_ident_change |=> bus_free;
  endproperty
  a_ident_change: assert property (p_ident_change) else $error("unit switch");
  property p_atn_with_msg;
    out_valid |-> out_atn;
  endproperty
  a_atn_with_msg: assert property (p_atn_with_msg) else $error("message without attention");
endmodule
`default_nettype wire

// *** test/scsi_target_message_handler_tb.sv ***
// testbench: target and initiator joined by the link, random and corner traffic
// assumes the package, interface, both ends and the checker compile first
`timescale 1ns/1ps
`default_nettype none
module scsi_target_message_handler_tb;
  import stm_pkg::*;
  logic core_clk, rst_n, sel_start, msg_valid, msg_ready, resel_start, resel_tagged, oth, dis;
  logic action_stb, ua_all, ua_oth, udisc, ext_stb, rx_stb, tag_valid, nexus_valid, bfs;
  logic [7:0] msg_byte, rx_byte, tag_value, ext_code, rx_last, t;
  logic [3:0] resel_lun, nexus_lun;
  logic [31:0] saved_ptr, cur_ptr;
  logic [2:0] l;
  logic [9:0] ext_seen;
  logic [7:0] q[$];
  logic [7:0] codes[7];
  stm_action_t action;
  stm_ext_t ext_kind;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 45141;
  int cnt[8];
  int w, n;
  stm_link_if u_stm_link_if();
  stm_target u_stm_target (.link(u_stm_link_if), .core_clk(core_clk), .rst_n(rst_n),
    .resel_lun(resel_lun), .resel_start(resel_start), .resel_tagged(resel_tagged),
    .other_init_active(oth), .nexus_lun(nexus_lun), .nexus_valid(nexus_valid),
    .tag_valid(tag_valid),
    .tag_value(tag_value), .action(action), .action_stb(action_stb),
    .unit_atten_all(ua_all), .unit_atten_others(ua_oth), .unexpected_disc(udisc),
    .ext_done_stb(ext_stb), .ext_kind(ext_kind), .ext_code(ext_code));
  stm_initiator u_stm_initiator (.link(u_stm_link_if), .core_clk(core_clk), .rst_n(rst_n),
    .sel_start(sel_start), .msg_valid(msg_valid), .msg_byte(msg_byte), .msg_ready(msg_ready),
    .saved_ptr(saved_ptr), .disc_allowed(dis), .cur_ptr(cur_ptr), .rx_byte(rx_byte),
    .rx_stb(rx_stb), .bus_free_seen(bfs));
  stm_link_asserts u_stm_link_asserts (.core_clk(core_clk), .rst_n(rst_n),
    .out_valid(u_stm_link_if.out_valid), .out_ready(u_stm_link_if.out_ready),
    .out_byte(u_stm_link_if.out_byte), .out_atn(u_stm_link_if.out_atn),
    .in_valid(u_stm_link_if.in_valid),
    .in_ready(u_stm_link_if.in_ready), .in_byte(u_stm_link_if.in_byte),
    .bus_free(u_stm_link_if.bus_free), .reselect(u_stm_link_if.reselect),
    .select(u_stm_link_if.select));
  initial begin
    core_clk = 0;
    forever #12.5 core_clk = ~core_clk;
  end
  // pulse counters: action, bus free, attention all/others, disconnect, ext, inbound
  always @(posedge core_clk) begin
    if (action_stb) cnt[0]++;
    if (u_stm_link_if.bus_free) cnt[1]++;
    if (ua_all) cnt[2]++;
    if (ua_oth) cnt[3]++;
    if (udisc) cnt[4]++;
    if (ext_stb) cnt[5]++;
    if (ext_stb) ext_seen = {ext_kind, ext_code};
    if (rx_stb) cnt[6]++;
    if (rx_stb) rx_last = rx_byte;
    if (bfs) cnt[7]++;
  end
  function automatic stm_ext_t exp_kind(input logic [7:0] k);
    case (k)
      EXT_MODIFY_PTR: return STM_EXT_MODIFY;
      EXT_SYNC_REQ: return STM_EXT_SYNC;
      EXT_WIDE_REQ: return STM_EXT_WIDE;
      default: return STM_EXT_OTHER;
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one connection: optional selection, then every byte of q held until taken
  task automatic conn(input logic sel);
    cnt = '{default: 0};
    sel_start = sel;
    @(negedge core_clk);
    sel_start = 0;
    foreach (q[i]) begin
      msg_valid = 1;
      msg_byte = q[i];
      w = 0;
      do @(posedge core_clk); while (!msg_ready && ++w < 99);
      // a byte never taken counts as a mismatch
      if (w >= 99) n_errors++;
      @(negedge core_clk);
    end
    msg_valid = 0;
    repeat (30) @(negedge core_clk);
  endtask
  initial begin
    #500000;
    n_errors++;
    final_report();
  end
  initial begin
    {rst_n, sel_start, msg_valid, resel_start, resel_tagged, oth, dis} = '0;
    msg_byte = 8'h00;
    resel_lun = 4'h0;
    saved_ptr = 32'h0;
    repeat (2) @(negedge core_clk);
    rst_n = 1;
    repeat (2) begin
      l = 3'($random(seed));
      t = 8'($random(seed)) & 8'h7f;
      saved_ptr = $random(seed);
      q = '{{5'h10, l}, MSG_ABORT};
      conn(1);
      chk(action, STM_ACT_ABORT);
      chk(cnt[1], 1);
      chk(cnt[7], 1);
      chk(nexus_lun, l);
      chk(nexus_valid, 1);
      chk(cur_ptr, dis ? saved_ptr : 32'h0);
      q = '{MSG_ABORT};
      conn(1);
      chk(cnt[0], 0);
      chk(cnt[1], 1);
      q = '{MSG_BUS_DEV_RESET};
      conn(1);
      chk(action, STM_ACT_RESET);
      chk(cnt[2], 1);
      q = '{8'h40 | t};
      conn(1);
      chk(cnt[4], 1);
      q = '{{5'h10, l}, 8'(MSG_ORDERED_TAG - t[0]), t, MSG_ABORT_TAG};
      conn(1);
      chk({tag_valid, tag_value}, {1'b1, t});
      chk(action, STM_ACT_ABORT_TAG);
      for (int o = 0; o < 2; o++) begin
        oth = o[0];
        q = '{{5'h10, l}, MSG_CLEAR_QUEUE};
        conn(1);
        chk(action, STM_ACT_CLEAR_Q);
        chk(cnt[3], o);
      end
      q = '{{5'h10, l}, {5'h10, ~l}};
      conn(1);
      chk(cnt[1], 1);
      codes = '{8'h00, 8'h01, 8'h03, 8'h02, 8'h04 | t, 8'h80 | t, 8'h00};
      for (int k = 0; k < 7; k++) begin
        n = (k == 6) ? 0 : 1 + ($random(seed) & 3);
        q = '{{5'h10, l}, MSG_EXTENDED, 8'(n), codes[k]};
        repeat ((n == 0) ? 255 : n - 1) q.push_back(8'($random(seed)) & 8'h7f);
        q.push_back(MSG_ABORT);
        conn(1);
        chk(cnt[5], 1);
        chk(ext_seen, {exp_kind(codes[k]), codes[k]});
        chk(cnt[6], exp_kind(codes[k]) == STM_EXT_OTHER);
        chk(cnt[6] ? rx_last : MSG_REJECT, MSG_REJECT);
      end
      dis = 1;
      saved_ptr = $random(seed);
      resel_lun = {1'b0, l};
      // tagged-only reselection, so the nexus is not yet fully identified
      resel_tagged = 1;
      resel_start = 1;
      @(negedge core_clk);
      resel_start = 0;
      repeat (20) @(negedge core_clk);
      chk(rx_last, {5'h10, l});
      chk(cur_ptr, saved_ptr);
      q = '{MSG_ABORT_TAG};
      conn(0);
      chk(cnt[0], 0);
      chk(cnt[1], 1);
      resel_tagged = 0;
    end
    final_report();
  end
endmodule
`default_nettype wire
